// ### ext_bus_pins_pkg.sv
// Notes on behaviour
// - Maskable input selects falling edge or level; out of reset enabled, level.
// - Clearing its enable disables it; reset also sets the processor mask bit.
// - Both interrupt pins are always readable inputs with pull-up until cleared.
// - Nonmaskable input is level sensitive; its mask is set at reset.
// - A level-sensitive line still held low interrupts again as soon as its mask clears.
// - Mode pins sampled at reset pick the mode; later queue tracking; pulldowns.
// - Special mode pin pulls up as input; later debug or high tag input.
// - Single-chip: ports A and B are plain I/O; expanded: external bus.
// - Wide mode multiplexes 16-bit address and data, port A upper byte.
// - Narrow mode: 8-bit data on port A; word takes two cycles, high first.
// - Read/write pin is an input with pull-up until its enable is set.
// - Low-byte strobe is an input with pull-up until enabled; low tag shares it.
// - Queue tracking pins time-multiplex data movement and execution state.
// - Data bus enable is active low during bus clock high in expanded modes.
// - On stretched accesses it asserts only in the last quarter of the last cycle.
// - Its use follows the disable bit; enabled out of reset in expanded modes.
// - The shared pin may carry an inverted bus clock instead.
// - Calibration output is the slow divided clock, 50% duty, crystal rate at reset.
// - Data bus enable overrides calibration; calibration enable clear turns it off.
// - Low-byte strobe is active low, XNOR of address bit 0 and byte flag.
// - Bus clock is half the crystal rate; every clock halts in stop mode.
package ext_bus_pins_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_INT_TRIGGER = 8'h00;
   localparam logic [7:0] OFS_PULLUP      = 8'h04;
   localparam logic [7:0] OFS_PORT_E_ASGN = 8'h08;
   localparam logic [7:0] OFS_SLOW_DIV    = 8'h0C;
   localparam logic [7:0] OFS_STRETCH     = 8'h10;
   localparam logic [7:0] OFS_PA_DATA     = 8'h14;
   localparam logic [7:0] OFS_PA_DIR      = 8'h18;
   localparam logic [7:0] OFS_PB_DATA     = 8'h1C;
   localparam logic [7:0] OFS_PB_DIR      = 8'h20;
   localparam logic [7:0] OFS_PE_DATA     = 8'h24;
   localparam logic [7:0] OFS_PE_DIR      = 8'h28;
   localparam logic [7:0] OFS_CPU_MASK    = 8'h2C;
   localparam logic [7:0] OFS_STATUS      = 8'h30;

   // int_trigger_control_reg fields
   localparam int BIT_EDGE_SEL = 7;
   localparam int BIT_IRQ_EN   = 6;
   localparam logic [7:0] INT_TRIGGER_RST = 8'h40;
   // port_e_assign_reg fields
   localparam int BIT_RWE  = 0;
   localparam int BIT_LSTE = 1;
   localparam int BIT_ECLE = 2;
   localparam int BIT_QTE  = 3;
   localparam int BIT_CALIBRATION_OUT_ENABLE = 4;
   localparam int BIT_ICS  = 5;
   localparam int BIT_BUS_ENABLE_DISABLE_BIT = 7;
   localparam logic [7:0] PORT_E_ASGN_RST = 8'h80;
   // cpu mask fields
   localparam int BIT_IMASK = 0;
   localparam int BIT_XMASK = 1;
   localparam logic [1:0] CPU_MASK_RST = 2'h3;

   // Port E pin positions
   localparam int PE_NMI  = 0;
   localparam int PE_IRQ  = 1;
   localparam int PE_RW   = 2;
   localparam int PE_LSTR = 3;
   localparam int PE_BUS_CLOCK_OUT = 4;
   localparam int PE_MOD0 = 5;
   localparam int PE_MOD1 = 6;
   localparam int PE_DBE  = 7;

   // Latched mode {special_n, mode_1, mode_0}
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_NARROW = 2'h1;
   localparam logic [1:0] MODE_WIDE   = 2'h3;
   localparam logic [2:0] MODE_RST    = 3'h4;
   localparam int BIT_SPECIAL_N = 2;

   // Bus clock: four pclk per cycle, two low then two high
   localparam logic [1:0] PH_LAST   = 2'h3;
   localparam logic [1:0] PH_HIGH0  = 2'h2;
   localparam logic [7:0] ZERO8     = 8'h00;

   typedef enum logic {B_IDLE, B_CYCLE} bus_state_t;
endpackage

// ### ext_bus_pins.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pins
   import ext_bus_pins_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        stop_mode,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic        byte_access_flag,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   input  wire logic        irq_ack,
   output logic             irq_request,
   output logic             nmi_request,
   input  wire logic [1:0]  queue_move,
   input  wire logic [1:0]  queue_exec,
   input  wire logic        background_debug_pin_drive,
   input  wire logic        background_debug_pin_level,
   output logic             tag_high_input,
   output logic             tag_low_input,
   input  wire logic [7:0]  pa_in,
   output logic [7:0]       pa_out,
   output logic [7:0]       pa_oe_n,
   input  wire logic [7:0]  pb_in,
   output logic [7:0]       pb_out,
   output logic [7:0]       pb_oe_n,
   input  wire logic [7:0]  pe_in,
   output logic [7:0]       pe_out,
   output logic [7:0]       pe_oe_n,
   output logic [7:0]       pe_pullup,
   output logic [7:0]       pe_pulldown,
   input  wire logic        smod_in,
   output logic             smod_out,
   output logic             smod_oe_n,
   output logic             smod_pullup
);
   logic [7:0]  int_trigger_control_reg_r;
   logic        pullup_enable_r;
   logic [7:0]  port_e_assign_reg_r;
   logic [7:0]  slow_div_r;
   logic [7:0]  stretch_cfg_r;
   logic [7:0]  pa_data_r;
   logic [7:0]  pa_dir_r;
   logic [7:0]  pb_data_r;
   logic [7:0]  pb_dir_r;
   logic [7:0]  pe_data_r;
   logic [7:0]  pe_dir_r;
   logic [1:0]  cpu_mask_r;
   logic [2:0]  mode_r;
   logic        captured_r;
   logic [1:0]  phase_r;
   logic [7:0]  slow_cnt_r;
   logic        slow_clk_r;
   logic        irq_edge_r;
   logic        irq_prev_r;
   bus_state_t  bus_state_r;
   logic [15:0] addr_r;
   logic [15:0] wdata_r;
   logic        write_r;
   logic        byte_r;
   logic        second_r;
   logic [7:0]  stretch_left_r;
   logic [15:0] rdata_r;
   logic        rsp_valid_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;

   logic        expanded;
   logic        wide;
   logic        narrow;
   logic        bus_clk;
   logic        e_high;
   logic        busy;
   logic        last_edge;
   logic        last_cycle;
   logic        ap_write;
   logic        setup;
   logic        dbe_fn;
   logic        dbe_n;
   logic        icl_fn;
   logic        cal_fn;
   logic [7:0]  alt_en;
   logic [7:0]  alt_out;
   logic [7:0]  alt_in_only;
   logic [31:0] rd_word;
   logic        rd_hit;

   // Mode decode from the pins latched after reset
   assign expanded = (mode_r[1:0] == MODE_NARROW) || (mode_r[1:0] == MODE_WIDE);
   assign wide     = mode_r[1:0] == MODE_WIDE;
   assign narrow   = mode_r[1:0] == MODE_NARROW;

   // Bus clock phase: stop freezes it along with the slow divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 2'h0;
      end else if (!stop_mode) begin
         phase_r <= phase_r + 2'h1;
      end
   end
   assign bus_clk   = phase_r[1];
   assign e_high    = phase_r[1];
   assign last_edge = (phase_r == PH_LAST) && !stop_mode;

   // Slow divider clock; divide value 0 gives the crystal rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_cnt_r <= ZERO8;
         slow_clk_r <= 1'b0;
      end else if (!stop_mode) begin
         if (slow_cnt_r >= slow_div_r) begin
            slow_cnt_r <= ZERO8;
            slow_clk_r <= ~slow_clk_r; // toggling keeps 50% duty
         end else begin
            slow_cnt_r <= slow_cnt_r + 8'h01;
         end
      end
   end

   // Mode pins caught once, at the first edge after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         captured_r <= 1'b0;
         mode_r     <= MODE_RST;
      end else if (!captured_r) begin
         captured_r <= 1'b1;
         mode_r     <= {smod_in, pe_in[PE_MOD1], pe_in[PE_MOD0]};
      end
   end

   // APB decode; answer has no wait states, data registered at setup
   assign setup    = psel && !penable;
   assign ap_write = psel && penable && pwrite;
   assign pready   = psel && penable;
   assign prdata   = prdata_r;
   assign pslverr  = pslverr_r;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (paddr)
         OFS_INT_TRIGGER: rd_word[7:0] = int_trigger_control_reg_r;
         OFS_PULLUP:      rd_word[0]   = pullup_enable_r;
         OFS_PORT_E_ASGN: rd_word[7:0] = port_e_assign_reg_r;
         OFS_SLOW_DIV:    rd_word[7:0] = slow_div_r;
         OFS_STRETCH:     rd_word[7:0] = stretch_cfg_r;
         OFS_PA_DATA:     rd_word[7:0] = expanded ? pa_data_r : pa_in;
         OFS_PA_DIR:      rd_word[7:0] = pa_dir_r;
         OFS_PB_DATA:     rd_word[7:0] = expanded ? pb_data_r : pb_in;
         OFS_PB_DIR:      rd_word[7:0] = pb_dir_r;
         OFS_PE_DATA:     rd_word[7:0] = pe_in; // pins always readable
         OFS_PE_DIR:      rd_word[7:0] = pe_dir_r;
         OFS_CPU_MASK:    rd_word[1:0] = cpu_mask_r;
         OFS_STATUS:      rd_word[12:0] = {irq_edge_r, captured_r,
                                           mode_r, pe_in};
         default:         rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr_r <= !rd_hit;
      end
   end

   // Interrupt trigger and pull-up control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_trigger_control_reg_r <= INT_TRIGGER_RST;
         pullup_enable_r           <= 1'b1;
      end else if (ap_write) begin
         if (paddr == OFS_INT_TRIGGER) begin
            int_trigger_control_reg_r <= pwdata[7:0];
         end
         if (paddr == OFS_PULLUP) begin
            pullup_enable_r <= pwdata[0];
         end
      end
   end

   // Pin function assignment; bus enable and clock output follow the mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_e_assign_reg_r <= PORT_E_ASGN_RST;
      end else if (!captured_r) begin
         port_e_assign_reg_r[BIT_BUS_ENABLE_DISABLE_BIT] <= !((pe_in[PE_MOD1:PE_MOD0] ==
                                  MODE_NARROW) || (pe_in[PE_MOD1:PE_MOD0] ==
                                  MODE_WIDE));
         port_e_assign_reg_r[BIT_ECLE] <= !(smod_in &&
                                  (pe_in[PE_MOD1:PE_MOD0] == MODE_SINGLE));
      end else if (ap_write && paddr == OFS_PORT_E_ASGN) begin
         port_e_assign_reg_r <= pwdata[7:0];
      end
   end

   // Plain configuration and port registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_div_r    <= ZERO8;
         stretch_cfg_r <= ZERO8;
         pa_data_r     <= ZERO8;
         pa_dir_r      <= ZERO8;
         pb_data_r     <= ZERO8;
         pb_dir_r      <= ZERO8;
         pe_data_r     <= ZERO8;
         pe_dir_r      <= ZERO8;
      end else if (ap_write) begin
         unique case (paddr)
            OFS_SLOW_DIV: slow_div_r    <= pwdata[7:0];
            OFS_STRETCH:  stretch_cfg_r <= pwdata[7:0];
            OFS_PA_DATA:  pa_data_r     <= pwdata[7:0];
            OFS_PA_DIR:   pa_dir_r      <= pwdata[7:0];
            OFS_PB_DATA:  pb_data_r     <= pwdata[7:0];
            OFS_PB_DIR:   pb_dir_r      <= pwdata[7:0];
            OFS_PE_DATA:  pe_data_r     <= pwdata[7:0];
            OFS_PE_DIR:   pe_dir_r      <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Processor mask bits: set by reset, the nonmaskable one only cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_mask_r <= CPU_MASK_RST;
      end else if (ap_write && paddr == OFS_CPU_MASK) begin
         cpu_mask_r[BIT_IMASK] <= pwdata[BIT_IMASK];
         cpu_mask_r[BIT_XMASK] <= cpu_mask_r[BIT_XMASK] && pwdata[BIT_XMASK];
      end
   end

   // Falling-edge latch; a new edge beats a same-cycle acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_prev_r <= 1'b1;
         irq_edge_r <= 1'b0;
      end else begin
         irq_prev_r <= pe_in[PE_IRQ];
         if (irq_prev_r && !pe_in[PE_IRQ]) begin
            irq_edge_r <= 1'b1;
         end else if (irq_ack) begin
            irq_edge_r <= 1'b0;
         end
      end
   end

   // Level-mode requests are live pin levels, so a held line fires once a mask clears
   assign irq_request = int_trigger_control_reg_r[BIT_IRQ_EN] &&
                        !cpu_mask_r[BIT_IMASK] &&
                        (int_trigger_control_reg_r[BIT_EDGE_SEL] ?
                         irq_edge_r : !pe_in[PE_IRQ]);
   assign nmi_request = !cpu_mask_r[BIT_XMASK] && !pe_in[PE_NMI];

   // External bus sequencer, cycles start on a bus clock boundary
   assign busy       = bus_state_r == B_CYCLE;
   assign req_ready  = !busy && expanded && last_edge;
   assign last_cycle = stretch_left_r == ZERO8;
   assign rsp_valid  = rsp_valid_r;
   assign rsp_rdata  = rdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state_r    <= B_IDLE;
         addr_r         <= 16'h0000;
         wdata_r        <= 16'h0000;
         write_r        <= 1'b0;
         byte_r         <= 1'b0;
         second_r       <= 1'b0;
         stretch_left_r <= ZERO8;
         rdata_r        <= 16'h0000;
         rsp_valid_r    <= 1'b0;
      end else begin
         rsp_valid_r <= 1'b0;
         unique case (bus_state_r)
            B_IDLE: begin
               if (req_valid && req_ready) begin
                  bus_state_r    <= B_CYCLE;
                  addr_r         <= req_addr;
                  wdata_r        <= req_wdata;
                  write_r        <= req_write;
                  byte_r         <= byte_access_flag;
                  second_r       <= 1'b0;
                  stretch_left_r <= stretch_cfg_r;
               end
            end
            B_CYCLE: begin
               if (last_edge) begin
                  if (!last_cycle) begin
                     stretch_left_r <= stretch_left_r - 8'h01;
                  end else begin
                     if (wide) begin
                        rdata_r <= !byte_r ? {pa_in, pb_in} :
                                   {ZERO8, addr_r[0] ? pb_in : pa_in};
                     end else if (byte_r) begin
                        rdata_r <= {ZERO8, pa_in};
                     end else if (!second_r) begin
                        rdata_r[15:8] <= pa_in; // high byte first
                     end else begin
                        rdata_r[7:0] <= pa_in;
                     end
                     if (narrow && !byte_r && !second_r) begin
                        second_r       <= 1'b1; // back-to-back
                        addr_r         <= addr_r + 16'h0001;
                        stretch_left_r <= stretch_cfg_r;
                     end else begin
                        bus_state_r <= B_IDLE;
                        rsp_valid_r <= 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Ports A and B: address in low phase; data in high phase on A, and on B in wide mode only
   always_comb begin
      pa_out  = pa_data_r;
      pa_oe_n = ~pa_dir_r;
      pb_out  = pb_data_r;
      pb_oe_n = ~pb_dir_r;
      if (expanded) begin
         pa_out  = addr_r[15:8];
         pa_oe_n = {8{!busy}};
         pb_out  = addr_r[7:0];
         pb_oe_n = {8{!busy}};
         if (busy && e_high) begin
            if (wide) begin
               pa_out  = byte_r ? wdata_r[7:0] : wdata_r[15:8];
               pb_out  = wdata_r[7:0];
               pa_oe_n = {8{!write_r}};
               pb_oe_n = {8{!write_r}};
            end else begin
               pa_out  = (byte_r || second_r) ? wdata_r[7:0]
                                              : wdata_r[15:8];
               pa_oe_n = {8{!write_r}};
            end
         end
      end
   end

   // Shared pin 7: bus enable first, then inverted clock, then calibration
   assign dbe_fn = !port_e_assign_reg_r[BIT_BUS_ENABLE_DISABLE_BIT] && expanded;
   assign icl_fn = port_e_assign_reg_r[BIT_BUS_ENABLE_DISABLE_BIT] &&
                   port_e_assign_reg_r[BIT_ICS];
   assign cal_fn = port_e_assign_reg_r[BIT_CALIBRATION_OUT_ENABLE];
   assign dbe_n  = !(e_high && (!busy || stretch_cfg_r == ZERO8 ||
                   (last_cycle && phase_r == PH_LAST)));

   always_comb begin
      alt_en  = ZERO8;
      alt_out = ZERO8;
      alt_in_only = ZERO8;
      alt_in_only[PE_NMI] = 1'b1; // never driven
      alt_in_only[PE_IRQ] = 1'b1;
      alt_en[PE_RW]   = port_e_assign_reg_r[BIT_RWE] && expanded;
      alt_out[PE_RW]  = !(busy && write_r);
      alt_en[PE_LSTR] = port_e_assign_reg_r[BIT_LSTE] && expanded;
      alt_out[PE_LSTR] = busy ? ~(addr_r[0] ^ byte_r) : 1'b1;
      alt_en[PE_BUS_CLOCK_OUT]  = port_e_assign_reg_r[BIT_ECLE];
      alt_out[PE_BUS_CLOCK_OUT] = bus_clk;
      alt_en[PE_MOD0]  = port_e_assign_reg_r[BIT_QTE] && expanded;
      alt_en[PE_MOD1]  = alt_en[PE_MOD0];
      alt_out[PE_MOD0] = e_high ? queue_exec[0] : queue_move[0];
      alt_out[PE_MOD1] = e_high ? queue_exec[1] : queue_move[1];
      alt_en[PE_DBE]   = dbe_fn || icl_fn || cal_fn;
      if (dbe_fn) begin
         alt_out[PE_DBE] = dbe_n; // overrides calibration
      end else if (icl_fn) begin
         alt_out[PE_DBE] = ~bus_clk;
      end else begin
         alt_out[PE_DBE] = slow_clk_r;
      end
   end

   // Per-pin fallback to the port registers
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pe
         assign pe_out[gi]  = alt_en[gi] ? alt_out[gi] : pe_data_r[gi];
         assign pe_oe_n[gi] = alt_in_only[gi] || !captured_r ||
                              (alt_en[gi] ? 1'b0 : !pe_dir_r[gi]);
      end
   endgenerate

   // Pulls: interrupt pins under pull-up enable, mode pins during reset
   always_comb begin
      pe_pullup   = ZERO8;
      pe_pulldown = ZERO8;
      pe_pullup[PE_NMI]      = pullup_enable_r;
      pe_pullup[PE_IRQ]      = pullup_enable_r;
      pe_pullup[PE_RW]       = !alt_en[PE_RW] && !pe_dir_r[PE_RW];
      pe_pullup[PE_LSTR]     = !alt_en[PE_LSTR] && !pe_dir_r[PE_LSTR];
      pe_pulldown[PE_MOD0]   = !captured_r;
      pe_pulldown[PE_MOD1]   = !captured_r;
   end

   // Special mode pin turns into the debug pin after reset
   assign smod_out       = background_debug_pin_level;
   assign smod_oe_n      = !(captured_r && background_debug_pin_drive);
   assign smod_pullup    = smod_oe_n;
   assign tag_high_input = captured_r && !smod_in;
   assign tag_low_input  = expanded && !mode_r[BIT_SPECIAL_N] &&
                           !pe_in[PE_LSTR];
endmodule // ext_bus_pins
`default_nettype wire

// ### ext_bus_pins_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pins_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        stop_mode,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [15:0] req_addr,
   input wire logic        rsp_valid,
   input wire logic        irq_request,
   input wire logic        nmi_request,
   input wire logic [7:0]  pa_out,
   input wire logic [7:0]  pa_oe_n,
   input wire logic [7:0]  pb_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Accept, then address held on both ports for the low half of E
   sequence s_acc; req_valid && req_ready; endsequence
   sequence s_addr;
      (pa_oe_n == 8'h00 && {pa_out, pb_out} == $past(req_addr))
      ##1 ($stable(pa_out) && $stable(pb_out));
   endsequence
   property p_ready; pready == (psel && penable); endproperty
   property p_err; psel && !penable && paddr > 8'h30
      |=> pslverr && prdata == 32'h0; endproperty
   property p_mask_rst; $rose(presetn)
      |-> (!irq_request && !nmi_request) [*4]; endproperty
   property p_gap; req_ready |=> !req_ready [*3]; endproperty
   property p_stop; stop_mode |-> !req_ready; endproperty
   property p_addr; s_acc |=> s_addr; endproperty
   property p_rsp; s_acc |-> ##[4:16] rsp_valid; endproperty
   property p_pulse; rsp_valid |=> !rsp_valid; endproperty
   a_ready: assert property (p_ready)
      else $error("pready not tied to access phase");
   a_err: assert property (p_err)
      else $error("unmapped access not refused");
   a_mask_rst: assert property (p_mask_rst)
      else $error("interrupt request while masked after reset");
   a_gap: assert property (p_gap)
      else $error("bus cycle shorter than four clocks");
   a_stop: assert property (p_stop)
      else $error("bus accepts while stopped");
   a_addr: assert property (p_addr)
      else $error("address not on ports after accept");
   a_rsp: assert property (p_rsp)
      else $error("no response after accept");
   a_pulse: assert property (p_pulse)
      else $error("response pulse too long");
endmodule // ext_bus_pins_asserts
bind ext_bus_pins ext_bus_pins_asserts u_chk (.pclk, .presetn, .psel,
   .penable, .paddr, .pready, .prdata, .pslverr, .stop_mode, .req_valid,
   .req_ready, .req_addr, .rsp_valid, .irq_request, .nmi_request, .pa_out,
   .pa_oe_n, .pb_out);
`default_nettype wire

// ### ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Wide-mode word memory; narrow byte lanes are not modelled
module ext_mem_model (
   input wire logic        pclk,
   input wire logic        bus_clock_out,
   input wire logic [7:0]  pa_out,
   input wire logic [7:0]  pa_oe_n,
   input wire logic [7:0]  pb_out,
   output logic [15:0]     drv
);
   logic [15:0] mem [0:255];
   logic [15:0] addr_r;
   logic [15:0] last_r = 16'h0000;
   logic        rd;
   // Drive only while E high and the device has let go of port A
   assign rd  = bus_clock_out && (pa_oe_n == 8'hFF);
   assign drv = rd ? mem[addr_r[8:1]] : ~last_r; // released: no stale data
   // Transparent latch while E low keeps the longest address setup
   always_ff @(posedge pclk) begin
      if (!bus_clock_out) addr_r <= {pa_out, pb_out};
      if (bus_clock_out && pa_oe_n == 8'h00) mem[addr_r[8:1]] <= {pa_out, pb_out};
      if (rd) last_r <= drv;
   end
endmodule // ext_mem_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ext_bus_pins_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, stop_mode = 1'b0, req_valid = 1'b0, irq_ack = 1'b0;
   logic req_write = 1'b0, byte_flag = 1'b0, smod_in = 1'b1, err, seen;
   logic [7:0]  paddr = 8'h00, pe_ext = 8'hFF;
   logic [31:0] pwdata = 32'h0, rd_data;
   logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, drv;
   logic pready, pslverr, req_ready, rsp_valid, irq_request, nmi_request;
   logic [31:0] prdata;
   logic [15:0] rsp_rdata;
   logic [7:0]  pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
   logic [7:0]  pe_in, pe_out, pe_oe_n, pe_pullup, pe_pulldown;
   int fail_count = 0, n_tests = 0;
   // Wire levels: device drive wins, else memory or pulled-up sources
   assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & drv[15:8]);
   assign pb_in = (~pb_oe_n & pb_out) | (pb_oe_n & drv[7:0]);
   assign pe_in = (~pe_oe_n & pe_out) | (pe_oe_n & pe_ext);
   initial forever #5 pclk = ~pclk;
   ext_bus_pins uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .stop_mode, .req_valid,
      .req_ready, .req_write, .byte_access_flag(byte_flag), .req_addr,
      .req_wdata, .rsp_valid, .rsp_rdata, .irq_ack, .irq_request,
      .nmi_request, .queue_move(2'h0), .queue_exec(2'h0), .background_debug_pin_drive(1'b0),
      .background_debug_pin_level(1'b1), .tag_high_input(), .tag_low_input(), .pa_in,
      .pa_out, .pa_oe_n, .pb_in, .pb_out, .pb_oe_n, .pe_in, .pe_out,
      .pe_oe_n, .pe_pullup, .pe_pulldown, .smod_in, .smod_out(),
      .smod_oe_n(), .smod_pullup());
   ext_mem_model mem (.pclk, .bus_clock_out(pe_in[4]), .pa_out, .pa_oe_n, .pb_out,
      .drv);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         fail_count++;
         end_sim();
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd_data = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      tmo(n);
      @(posedge pclk); // Let the write settle before checks
   endtask
   // One expansion bus request and its response
   task automatic breq(input logic w, input logic [15:0] a, input logic [15:0] d);
      int n;
      @(posedge pclk);
      {req_valid, req_write, req_addr, req_wdata} <= {1'b1, w, a, d};
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         if (req_ready === 1'b1) break;
      end
      req_valid <= 1'b0;
      tmo(n);
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         if (rsp_valid === 1'b1) break;
      end
      tmo(n);
   endtask
   task automatic rst(input logic [1:0] m);
      @(posedge pclk);
      {presetn, pe_ext} <= {1'b0, 1'b1, m, 5'h1F};
      repeat (5) @(posedge pclk);
      chk(32'(pe_oe_n), 32'hFF);
      chk(32'(pe_pulldown[6:5]), 32'h3);
      chk(32'(pe_pullup[1:0]), 32'h3);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask
   task automatic t_regs;
      apb(0, OFS_INT_TRIGGER, 0);
      chk(rd_data, 32'(INT_TRIGGER_RST));
      apb(0, OFS_CPU_MASK, 0);
      chk(rd_data, 32'(CPU_MASK_RST));
      apb(0, OFS_PORT_E_ASGN, 0);
      chk(rd_data, 32'h04);
      apb(0, OFS_STATUS, 0);
      chk({rd_data[11:8], rd_data[7] ^ rd_data[4], rd_data[6:5],
           rd_data[3:0]}, 32'h7FF);
      apb(0, 8'h40, 0);
      chk(32'(err), 1);
      chk(rd_data, 0);
      $display("test regs done");
   endtask
   task automatic t_irq;
      {pe_ext[1], pe_ext[0]} <= 2'b00;
      repeat (4) @(posedge pclk);
      chk({irq_request, nmi_request}, 2'b00);
      apb(1, OFS_CPU_MASK, 0);
      repeat (2) @(posedge pclk);
      chk({irq_request, nmi_request}, 2'b11);
      apb(1, OFS_INT_TRIGGER, 32'h0);
      chk(irq_request, 0);
      apb(1, OFS_INT_TRIGGER, 32'hC0);
      pe_ext[1] <= 1'b1;
      repeat (4) @(posedge pclk);
      pe_ext[1] <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(irq_request, 1);
      irq_ack <= 1'b1;
      @(posedge pclk) irq_ack <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(irq_request, 0);
      pe_ext[1:0] <= 2'b11;
      apb(1, OFS_PULLUP, 0);
      chk(32'(pe_pullup[1:0]), 0);
      $display("test irq done");
   endtask
   task automatic t_bus;
      apb(1, OFS_PORT_E_ASGN, 32'h07);
      chk(pe_oe_n[2], 0);
      breq(1, 16'h0024, 16'hBEEF);
      breq(1, 16'h0026, 16'h1234);
      breq(0, 16'h0024, 0);
      chk(rsp_rdata, 16'hBEEF);
      seen = 1'b0;
      {stop_mode, req_valid} <= 2'b11;
      repeat (12) @(posedge pclk) seen |= req_ready;
      {stop_mode, req_valid} <= 2'b00;
      chk(seen, 0);
      $display("test bus done");
   endtask
   task automatic t_single;
      rst(2'h0);
      apb(1, OFS_PA_DIR, 32'hFF);
      apb(1, OFS_PA_DATA, 32'hA5);
      chk({pa_oe_n, pa_out}, 16'h00A5);
      seen = 1'b0;
      req_valid <= 1'b1;
      repeat (12) @(posedge pclk) seen |= req_ready;
      req_valid <= 1'b0;
      chk(seen, 0);
      $display("test single done");
   endtask
   initial begin
      rst(2'h3);
      t_regs();
      t_irq();
      t_bus();
      t_single();
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
